// >>> src/crpm_params.svh
`ifndef CRPM_PARAMS_SVH
`define CRPM_PARAMS_SVH
// Register byte offsets
`define CRPM_OFF_CTRL 12'h000
`define CRPM_OFF_CLKS 12'h004
`define CRPM_OFF_PLL 12'h008
`define CRPM_OFF_STAT 12'h00C
`define CRPM_OFF_RST 12'h010
// CLKS field positions
`define CRPM_CLKS_BUSSEL 7
`define CRPM_CLKS_PARTIAL_STOP_ENABLE 6
`define CRPM_CLKS_WATCHDOG_AUX_CLOCK_STOP_DISABLE 5
`define CRPM_CLKS_WDSEL1 4
`define CRPM_CLKS_TICKPE 3
`define CRPM_CLKS_WDPE 2
`define CRPM_CLKS_TICKSEL 1
`define CRPM_CLKS_WDSEL0 0
// CTRL field positions
`define CRPM_CTRL_CRYSTAL_OSC_ENABLE 0
`define CRPM_CTRL_HALTDBG 1
`define CRPM_CTRL_RATE_LSB 4
// Reset values and maximum watchdog rate
`define CRPM_CLKS_RESET 8'h80
`define CRPM_VCO_MHZ 50
`define CRPM_POSTDIV_RESET 5'h03
`define CRPM_REFERENCE_DIVIDER_RESET 4'h0
`define CRPM_RATE_MAX 3'h7
// Timing
`define CRPM_CLK_MHZ 40
`define CRPM_SWITCH_NS 100
`define CRPM_SWITCH_CYC ((`CRPM_SWITCH_NS * `CRPM_CLK_MHZ + 999) / 1000)
`define CRPM_ACLK_LAT_NS 2000
`define CRPM_ACLK_LAT_CYC ((`CRPM_ACLK_LAT_NS * `CRPM_CLK_MHZ + 999) / 1000)
`endif

// >>> src/crpm_pkg.sv
package crpm_pkg;
  typedef enum logic [1:0] {
    CRPM_RUN = 2'b00,
    CRPM_FULL_STOP = 2'b01,
    CRPM_PSEUDO_STOP = 2'b10
  } crpm_mode_t;
  typedef enum logic [1:0] {
    CRPM_PEI = 2'b00,
    CRPM_PEE = 2'b01,
    CRPM_PBE = 2'b10
  } crpm_clk_mode_t;
  typedef struct packed {
    logic power_on;
    logic low_voltage;
    logic illegal_addr;
    logic watchdog;
    logic clock_monitor;
    logic ext_pin;
  } crpm_rst_src_t;
  typedef struct packed {
    logic bus;
    logic core;
    logic debug;
    logic watchdog;
    logic tick;
    logic aclk_wd;
  } crpm_gate_t;
endpackage

// >>> src/crpm_top.sv
// Overview of operation
// - Reset enters loop-engaged-internal mode, bus clock from loop output clock
// - Reset loop setup: 50MHz oscillator core, post-divider 0x03, bus 6.25MHz
// - Internal mode takes loop reference from internal 1MHz reference
// - Bypassed mode: bus from crystal clock, loop stays running to qualify
// - Run: full performance, loop and reference on, voltage monitors available
// - Wait mode behaves exactly as run mode
// - Stop instruction turns off loop and reference, stops core, bus, debug clocks
// - Stop keeps autonomous clock, power-on reset, periodic interrupt; monitors off
// - Partial stop when partial-stop and oscillator enable both set, else full
// - Full stop disables crystal oscillator and halts periodic tick
// - Full stop with upper watchdog select low also halts watchdog
// - Full stop wake: bus from loop, watchdog and tick on internal reference
// - Full stop wake with upper select high keeps watchdog on autonomous clock
// - Autonomous watchdog clock stops in stop when stop-disable set
// - Stop-disable set adds latency entering and leaving stop; watchdog resumes
// - Partial stop keeps oscillator running and clock select bits unchanged
// - Partial stop, upper select low: watchdog, tick run on crystal if enabled
// - Partial stop, upper select high: tick per enable, watchdog autonomous rule
// - Debug as run, tick and watchdog halt if halt bit, watchdog max rate
// - System reset from power-on, low voltage, illegal, watchdog, monitor, pin
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "crpm_params.svh"
module crpm_top import crpm_pkg::*; (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core events
  input wire logic STOP_REQ,
  input wire logic WAKE_REQ,
  input wire logic DEBUG_ACTIVE,
  // Analog status, asynchronous
  input wire logic OSC_UP_IN,
  input wire logic LOCK_IN,
  // Reset sources, asynchronous
  input wire logic POR_IN,
  input wire logic LVR_IN,
  input wire logic ILLEGAL_ADDR_IN,
  input wire logic WATCHDOG_TIMEOUT_IN,
  input wire logic CLOCK_MONITOR_FAIL_IN,
  input wire logic RESET_PIN_IN,
  // Reset pin, open drain
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE_N,
  // Clock control
  output logic BUS_SRC_LOOP,
  output logic LOOP_ENABLE,
  output logic LOOP_REF_CRYSTAL,
  output logic REF_1MHZ_ENABLE,
  output logic CRYSTAL_OSC_ENABLE,
  output logic FULL_PERFORMANCE,
  output logic LV_MONITOR_ENABLE,
  output logic [5:0] LOOP_VCO_MHZ,
  output logic [4:0] LOOP_POSTDIV,
  output logic [3:0] LOOP_REFERENCE_DIVIDER,
  output crpm_gate_t CLOCK_GATES,
  output logic WATCHDOG_ON_CRYSTAL,
  output logic TICK_ON_CRYSTAL,
  output logic [2:0] WATCHDOG_RATE,
  output logic [1:0] POWER_MODE,
  output logic SYSTEM_RESET
);
  localparam int SW_CYC = `CRPM_SWITCH_CYC;
  localparam int LAT_CYC = `CRPM_ACLK_LAT_CYC;

  logic [7:0] clks;
  logic crystal_osc_enable, halt_in_debug;
  logic [2:0] watchdog_rate;
  logic [5:0] vco;
  logic [4:0] postdiv;
  logic [3:0] reference_divider;
  crpm_mode_t mode;
  crpm_rst_src_t rst_flags;
  logic bus_cur;
  logic [7:0] sw_cnt;
  logic [7:0] lat_cnt;
  logic aclk_wd_run;
  // Three-stage synchronisers for asynchronous inputs
  // Stages two and three must agree, so a one-cycle glitch is ignored
  logic [7:0] s1, s2, s3;
  wire logic [7:0] async_in = {OSC_UP_IN, LOCK_IN, POR_IN, LVR_IN, ILLEGAL_ADDR_IN,
                               WATCHDOG_TIMEOUT_IN, CLOCK_MONITOR_FAIL_IN, RESET_PIN_IN};
  logic [7:0] filt;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          filt[gi] <= 1'b0;
        end else begin
          s1[gi] <= async_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            filt[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate
  wire logic osc_up = filt[7];
  wire logic lock = filt[6];
  wire logic [5:0] rst_req = filt[5:0];

  wire logic wr = PSEL && PENABLE && PWRITE;
  wire logic bus_sel = clks[`CRPM_CLKS_BUSSEL];
  wire logic wd_sel1 = clks[`CRPM_CLKS_WDSEL1];
  wire logic watchdog_aux_clock_stop_disable = clks[`CRPM_CLKS_WATCHDOG_AUX_CLOCK_STOP_DISABLE];
  wire logic in_stop = (mode != CRPM_RUN);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      vco <= 6'(`CRPM_VCO_MHZ);
      postdiv <= `CRPM_POSTDIV_RESET;
      reference_divider <= `CRPM_REFERENCE_DIVIDER_RESET;
    end else if (wr && PADDR == `CRPM_OFF_PLL) begin
      vco <= PWDATA[5:0];
      postdiv <= PWDATA[12:8];
      reference_divider <= PWDATA[19:16];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      crystal_osc_enable <= 1'b0;
      halt_in_debug <= 1'b0;
      watchdog_rate <= 3'h0;
    end else if (wr && PADDR == `CRPM_OFF_CTRL) begin
      crystal_osc_enable <= PWDATA[`CRPM_CTRL_CRYSTAL_OSC_ENABLE];
      halt_in_debug <= PWDATA[`CRPM_CTRL_HALTDBG];
      watchdog_rate <= PWDATA[`CRPM_CTRL_RATE_LSB +: 3];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      clks <= `CRPM_CLKS_RESET;
    end else if (mode == CRPM_FULL_STOP && WAKE_REQ) begin
      clks[`CRPM_CLKS_BUSSEL] <= 1'b1;
      clks[`CRPM_CLKS_TICKSEL] <= 1'b0;
      clks[`CRPM_CLKS_WDSEL0] <= 1'b0;
      // keep autonomous watchdog via upper select untouched
      // Writes dropped in stop; the core is halted there anyway
    end else if (wr && PADDR == `CRPM_OFF_CLKS && !in_stop) begin
      clks <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode <= CRPM_RUN;
    end else begin
      unique case (mode)
        CRPM_RUN: begin
          if (STOP_REQ) begin
            mode <= (clks[`CRPM_CLKS_PARTIAL_STOP_ENABLE] && crystal_osc_enable) ? CRPM_PSEUDO_STOP : CRPM_FULL_STOP;
          end
        end
        CRPM_FULL_STOP, CRPM_PSEUDO_STOP: begin
          if (WAKE_REQ) begin
            mode <= CRPM_RUN;
          end
        end
        default: mode <= CRPM_RUN;
      endcase
    end
  end

  // glitch-free switch
  // Source changes only after a settle count so neither clock is cut short
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bus_cur <= 1'b1;
      sw_cnt <= 8'h00;
    end else if (bus_cur == bus_sel) begin
      sw_cnt <= 8'h00;
    end else if (sw_cnt == 8'(SW_CYC - 1)) begin
      bus_cur <= bus_sel;
      sw_cnt <= 8'h00;
    end else begin
      sw_cnt <= sw_cnt + 8'h01;
    end
  end

  // stop entry and exit latency
  // Both edges of stop pay the same settle cost for the autonomous clock
  wire logic want_aclk = !(in_stop && watchdog_aux_clock_stop_disable);
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aclk_wd_run <= 1'b1;
      lat_cnt <= 8'h00;
    end else if (aclk_wd_run == want_aclk) begin
      lat_cnt <= 8'h00;
    end else if (lat_cnt == 8'(LAT_CYC - 1)) begin
      aclk_wd_run <= want_aclk;
      lat_cnt <= 8'h00;
    end else begin
      lat_cnt <= lat_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_flags <= '0;
    end else if (wr && PADDR == `CRPM_OFF_RST) begin
      rst_flags <= (rst_flags & ~crpm_rst_src_t'(PWDATA[5:0])) | crpm_rst_src_t'(rst_req);
    end else begin
      rst_flags <= rst_flags | crpm_rst_src_t'(rst_req);
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_SRC_LOOP <= 1'b1;
      LOOP_ENABLE <= 1'b1;
      LOOP_REF_CRYSTAL <= 1'b0;
      REF_1MHZ_ENABLE <= 1'b1;
      CRYSTAL_OSC_ENABLE <= 1'b0;
      FULL_PERFORMANCE <= 1'b1;
      LV_MONITOR_ENABLE <= 1'b1;
      LOOP_VCO_MHZ <= 6'(`CRPM_VCO_MHZ);
      LOOP_POSTDIV <= `CRPM_POSTDIV_RESET;
      LOOP_REFERENCE_DIVIDER <= `CRPM_REFERENCE_DIVIDER_RESET;
      CLOCK_GATES <= '0;
      WATCHDOG_ON_CRYSTAL <= 1'b0;
      TICK_ON_CRYSTAL <= 1'b0;
      WATCHDOG_RATE <= 3'h0;
      POWER_MODE <= 2'b00;
      SYSTEM_RESET <= 1'b0;
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE_N <= 1'b1;
    end else begin
      BUS_SRC_LOOP <= bus_cur;
      LOOP_ENABLE <= !in_stop;
      REF_1MHZ_ENABLE <= !in_stop;
      LOOP_REF_CRYSTAL <= crystal_osc_enable && osc_up;
      CRYSTAL_OSC_ENABLE <= crystal_osc_enable && (mode != CRPM_FULL_STOP);
      FULL_PERFORMANCE <= !in_stop;
      LV_MONITOR_ENABLE <= !in_stop;
      LOOP_VCO_MHZ <= vco;
      LOOP_POSTDIV <= postdiv;
      LOOP_REFERENCE_DIVIDER <= reference_divider;
      CLOCK_GATES.bus <= !in_stop;
      CLOCK_GATES.core <= !in_stop;
      CLOCK_GATES.debug <= !in_stop;
      CLOCK_GATES.aclk_wd <= wd_sel1 && aclk_wd_run;
      unique case (mode)
        CRPM_FULL_STOP: begin
          CLOCK_GATES.watchdog <= wd_sel1 && aclk_wd_run;
          CLOCK_GATES.tick <= 1'b0;
        end
        CRPM_PSEUDO_STOP: begin
          CLOCK_GATES.watchdog <= wd_sel1 ? aclk_wd_run : clks[`CRPM_CLKS_WDPE];
          CLOCK_GATES.tick <= clks[`CRPM_CLKS_TICKPE];
        end
        default: begin
          CLOCK_GATES.watchdog <= !(DEBUG_ACTIVE && halt_in_debug);
          CLOCK_GATES.tick <= !(DEBUG_ACTIVE && halt_in_debug);
        end
      endcase
      WATCHDOG_ON_CRYSTAL <= (mode == CRPM_PSEUDO_STOP) ? !wd_sel1 : clks[`CRPM_CLKS_WDSEL0];
      TICK_ON_CRYSTAL <= (mode == CRPM_PSEUDO_STOP) ? 1'b1 : clks[`CRPM_CLKS_TICKSEL];
      WATCHDOG_RATE <= DEBUG_ACTIVE ? `CRPM_RATE_MAX : watchdog_rate;
      POWER_MODE <= mode;
      SYSTEM_RESET <= |rst_req;
      RESET_PIN_OE_N <= ~|rst_req[5:1];
    end
  end

  // APB slave, zero wait states
  // Read data latched at setup so it stands through the access cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE) begin
        unique case (PADDR)
          `CRPM_OFF_CTRL: PRDATA <= {25'h0, watchdog_rate, 2'b00, halt_in_debug, crystal_osc_enable};
          `CRPM_OFF_CLKS: PRDATA <= {24'h0, clks};
          `CRPM_OFF_PLL: PRDATA <= {12'h0, reference_divider, 3'h0, postdiv, 2'b00, vco};
          `CRPM_OFF_STAT: PRDATA <= {24'h0, 1'b0, aclk_wd_run, mode, bus_cur, lock, osc_up, in_stop};
          `CRPM_OFF_RST: PRDATA <= {26'h0, rst_flags};
          default: begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b1;
          end
        endcase
      end
    end
  end

  // Assertions
  a_bus_switch_delay: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $changed(bus_cur) |-> $past(bus_sel) == bus_cur && $past(sw_cnt) == 8'(SW_CYC - 1))
    else $error("bus source switched early");
  a_run_resources: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !in_stop |=> LOOP_ENABLE && REF_1MHZ_ENABLE && FULL_PERFORMANCE && LV_MONITOR_ENABLE) else $error("run resource off");
  a_wake_keep_upper: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_FULL_STOP && WAKE_REQ) |=> $stable(wd_sel1)) else $error("upper select changed on wake");
  a_pseudo_clks_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
    mode == CRPM_PSEUDO_STOP |=> $stable(clks)) else $error("select bits changed in partial stop");
  a_pseudo_gates: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_PSEUDO_STOP && !wd_sel1) |=> CLOCK_GATES.watchdog == $past(clks[`CRPM_CLKS_WDPE]) &&
    CLOCK_GATES.tick == $past(clks[`CRPM_CLKS_TICKPE])) else $error("partial stop gate wrong");
  a_full_stop_wd: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_FULL_STOP && !wd_sel1) |=> !CLOCK_GATES.watchdog) else $error("watchdog runs in full stop");
  a_debug_halt: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_RUN && DEBUG_ACTIVE && halt_in_debug) |=> !CLOCK_GATES.tick && !CLOCK_GATES.watchdog)
    else $error("debug halt ignored");
  a_reset_pin: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (|rst_req[5:1]) |=> !RESET_PIN_OE_N) else $error("reset pin not driven");
  a_stop_loop_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
    in_stop |=> !LOOP_ENABLE && !CLOCK_GATES.bus) else $error("loop on in stop");
  a_pseudo_select: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_RUN && STOP_REQ) |=> (mode == CRPM_PSEUDO_STOP) == $past(clks[6] && crystal_osc_enable))
    else $error("wrong stop type");
  a_full_stop_osc: assert property (@(posedge CLOCK) disable iff (!RST_N)
    mode == CRPM_FULL_STOP |=> !CRYSTAL_OSC_ENABLE && !CLOCK_GATES.tick) else $error("osc on in full stop");
  a_wake_selects: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == CRPM_FULL_STOP && WAKE_REQ) |=> clks[7] && !clks[1] && !clks[0]) else $error("wake select bad");
  a_stop_monitors: assert property (@(posedge CLOCK) disable iff (!RST_N)
    in_stop |=> !LV_MONITOR_ENABLE) else $error("monitor on in stop");
  a_debug_rate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    DEBUG_ACTIVE |=> WATCHDOG_RATE == 3'h7) else $error("debug rate not max");
  a_reset_out: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (|rst_req) |=> SYSTEM_RESET) else $error("reset not raised");
  a_aclk_latency: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(aclk_wd_run) |-> $past(lat_cnt) == 8'(LAT_CYC - 1)) else $error("latency skipped");
  // Cover points for the main scenarios
  c_full_stop: cover property (@(posedge CLOCK) mode == CRPM_FULL_STOP);
  c_aclk_stop: cover property (@(posedge CLOCK) $fell(aclk_wd_run));
  c_pseudo_stop: cover property (@(posedge CLOCK) mode == CRPM_PSEUDO_STOP);
  c_bus_switch: cover property (@(posedge CLOCK) $fell(bus_cur));
  c_debug_halt: cover property (@(posedge CLOCK) DEBUG_ACTIVE && halt_in_debug);
endmodule

// >>> verification/crpm_core_model.sv
`timescale 1ns/1ps
module crpm_core_model #(
  parameter int UP_CYC = 30,
  parameter int LOCK_CYC = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests from the unit
  input wire logic osc_enable,
  input wire logic loop_enable,
  // Status back to the unit
  output logic osc_up,
  output logic lock
);
  int osc_cnt;
  int lock_cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= 0;
    end else if (!osc_enable) begin
      osc_cnt <= 0;
    end else if (osc_cnt < UP_CYC) begin
      osc_cnt <= osc_cnt + 1;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= 0;
    end else if (!loop_enable) begin
      lock_cnt <= 0;
    end else if (lock_cnt < LOCK_CYC) begin
      lock_cnt <= lock_cnt + 1;
    end
  end
  assign osc_up = osc_cnt >= UP_CYC;
  assign lock = lock_cnt >= LOCK_CYC;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "crpm_params.svh"
module tb_top;
  logic CLOCK = 0;
  logic RST_N = 0;
  logic psel = 0, pen = 0, pwr = 0, stop_req = 0, wake_req = 0, dbg = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, clks;
  logic [5:0] src = 6'h00, vco;
  logic [4:0] pdiv;
  logic [3:0] rdiv;
  logic [2:0] rate;
  logic [1:0] pmode, m;
  logic pready, pslverr, er, osc_up, lock, oe_n, pin_out, bus_loop, loop_en, ref_xtal, ref_en;
  logic xosc_en, full_performance, lvm, wd_x, tk_x, sysrst;
  crpm_pkg::crpm_gate_t gates;
  int err_total = 0, checked = 0, cyc = 0;
  always #12.5 CLOCK = ~CLOCK;
  crpm_top u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STOP_REQ(stop_req),
    .WAKE_REQ(wake_req), .DEBUG_ACTIVE(dbg), .OSC_UP_IN(osc_up), .LOCK_IN(lock), .POR_IN(src[5]),
    .LVR_IN(src[4]), .ILLEGAL_ADDR_IN(src[3]), .WATCHDOG_TIMEOUT_IN(src[2]),
    .CLOCK_MONITOR_FAIL_IN(src[1]), .RESET_PIN_IN(src[0]), .RESET_PIN_OUT(pin_out),
    .RESET_PIN_OE_N(oe_n), .BUS_SRC_LOOP(bus_loop), .LOOP_ENABLE(loop_en), .LOOP_REF_CRYSTAL(ref_xtal),
    .REF_1MHZ_ENABLE(ref_en), .CRYSTAL_OSC_ENABLE(xosc_en), .FULL_PERFORMANCE(full_performance),
    .LV_MONITOR_ENABLE(lvm), .LOOP_VCO_MHZ(vco), .LOOP_POSTDIV(pdiv), .LOOP_REFERENCE_DIVIDER(rdiv),
    .CLOCK_GATES(gates), .WATCHDOG_ON_CRYSTAL(wd_x), .TICK_ON_CRYSTAL(tk_x), .WATCHDOG_RATE(rate),
    .POWER_MODE(pmode), .SYSTEM_RESET(sysrst));
  crpm_core_model u_core (.clock(CLOCK), .rst_n(RST_N), .osc_enable(xosc_en), .loop_enable(loop_en),
    .osc_up(osc_up), .lock(lock));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // Held until pready is sampled high at a rising edge, released at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK);
    pen <= 1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) cmp(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic pulse(input logic s);
    @(posedge CLOCK);
    if (s) stop_req <= 1;
    else wake_req <= 1;
    @(posedge CLOCK);
    stop_req <= 0;
    wake_req <= 0;
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    int i;
    void'($urandom(32'h17D2));
    repeat (16) @(posedge CLOCK);
    RST_N <= 1;
    idle(3);
    cmp(bus_loop, 32'h1);
    cmp({rdiv, vco, pdiv}, {17'h0, 4'h0, 6'h32, 5'h03});
    cmp(ref_xtal, 32'h0);
    cmp({loop_en, ref_en, full_performance, lvm, pmode}, 32'h3C);
    clks = $urandom & 32'h000F_1F3F;
    apb(1, `CRPM_OFF_PLL, clks);
    idle(2);
    cmp({rdiv, pdiv, vco}, {clks[19:16], clks[12:8], clks[5:0]});
    apb(0, `CRPM_OFF_CLKS, 32'h0);
    cmp(rd, 32'h80);
    apb(0, 12'h0FC, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    apb(1, `CRPM_OFF_CTRL, 32'h1);
    i = 0;
    do begin
      apb(0, `CRPM_OFF_STAT, 32'h0);
      i++;
    end while (rd[2:1] !== 2'b11 && i < 60);
    idle(2);
    cmp(ref_xtal, 32'h1);
    apb(1, `CRPM_OFF_CLKS, 32'h0);
    idle(2);
    cmp(bus_loop, 32'h1);
    idle(6);
    cmp({bus_loop, loop_en}, 32'h1);
    apb(1, `CRPM_OFF_CLKS, 32'h80);
    idle(8);
    cmp(bus_loop, 32'h1);
    for (i = 0; i < 8; i++) begin
      clks = ($urandom & 32'h2F) | 32'h80 | (32'(i[1]) << 6) | (32'(i[2]) << 4);
      apb(1, `CRPM_OFF_CTRL, 32'(i[0]));
      apb(1, `CRPM_OFF_CLKS, clks);
      idle(40);
      pulse(1);
      m = (i[1] && i[0]) ? 2'h2 : 2'h1;
      idle(10);
      if (clks[4] && clks[5]) cmp(gates.aclk_wd, 32'h1);
      idle(85);
      cmp(pmode, m);
      cmp({loop_en, ref_en, gates.bus, gates.core, gates.debug}, 32'h0);
      cmp({full_performance, lvm}, 32'h0);
      cmp(xosc_en, m == 2'h2);
      if (m == 2'h1) cmp(gates.tick, 32'h0);
      if (m == 2'h1 && !clks[4]) cmp(gates.watchdog, 32'h0);
      if (m == 2'h2) cmp(gates.tick, clks[3]);
      if (m == 2'h2 && !clks[4]) cmp(gates.watchdog, clks[2]);
      if (clks[4]) cmp(gates.aclk_wd, !clks[5]);
      if (m == 2'h2) cmp({wd_x, tk_x}, {!clks[4], 1'b1});
      pulse(0);
      idle(95);
      cmp({pmode, bus_loop}, 32'h1);
      if (clks[4]) cmp(gates.aclk_wd, 32'h1);
      cmp({wd_x, tk_x}, (m == 2'h1) ? 32'h0 : {clks[0], clks[1]});
      apb(0, `CRPM_OFF_CLKS, 32'h0);
      cmp(rd, (m == 2'h1) ? ((clks & 32'hFC) | 32'h80) : clks);
    end
    apb(1, `CRPM_OFF_CLKS, 32'h80);
    for (i = 0; i < 2; i++) begin
      apb(1, `CRPM_OFF_CTRL, 32'(i * 2));
      dbg <= 1;
      idle(6);
      cmp(rate, 32'h7);
      cmp({gates.bus, gates.tick, gates.watchdog}, i ? 32'h4 : 32'h7);
      @(posedge CLOCK);
      dbg <= 0;
    end
    for (i = 0; i < 6; i++) begin
      @(posedge CLOCK);
      src <= 6'h20 >> i;
      idle(8);
      cmp({sysrst, oe_n, pin_out}, {1'b1, i == 5, 1'b0});
      @(posedge CLOCK);
      src <= 6'h00;
      idle(8);
      apb(0, `CRPM_OFF_RST, 32'h0);
      cmp(rd[5:0], 6'h20 >> i);
      apb(1, `CRPM_OFF_RST, 32'h3F);
    end
    print_verdict();
  end
endmodule
